/* design/asl_host.sv */
// Host controller driving an asynchronous 16-bit SRAM with byte-lane enables
`timescale 1ns/1ps
module asl_host
  import asl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lane_n,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] sram_addr,
  output logic chip_select_low_active,
  output logic chip_select_high_active,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [DATA_W-1:0] data_lines_oe_n
);
  typedef struct packed {
    asl_state_t st;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_n;
    logic sel;
    logic we_n;
    logic oe_n;
    logic drive;
    logic rsp;
    logic [DATA_W-1:0] rdata;
  } asl_regs_t;

  asl_regs_t r_ff;
  asl_regs_t nxt_r;
  logic [DATA_W-1:0] din_sync;

  asl_sync2 #(.W(DATA_W)) u_sync
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(data_lines_in),
    .q(din_sync)
  );

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.rsp = 1'b0;
    case (r_ff.st)
      ASL_IDLE:
      begin
        nxt_r.sel = 1'b0;
        nxt_r.we_n = 1'b1;
        nxt_r.oe_n = 1'b1;
        nxt_r.drive = 1'b0;
        nxt_r.lane_n = LANES_NONE;
        if (req_valid && req_lane_n != LANES_NONE)
        begin
          // Address, selects and lane enables launch together; a read's gate too, a write's strobe one cycle later
          nxt_r.addr = req_addr;
          nxt_r.wdata = req_wdata;
          nxt_r.lane_n = req_lane_n;
          nxt_r.sel = 1'b1;
          if (req_write)
          begin
            // Gate stays high so device never drives
            nxt_r.st = ASL_TURN;
            nxt_r.cnt = TURN_CYC;
          end
          else
          begin
            nxt_r.st = ASL_RD;
            nxt_r.oe_n = 1'b0;
            nxt_r.cnt = RD_CYC + 4'h2;
          end
        end
      end
      ASL_RD:
      begin
        // Strobe held high all read long
        nxt_r.we_n = 1'b1;
        nxt_r.cnt = r_ff.cnt - 4'h1;
        if (r_ff.cnt == 4'h1)
        begin
          nxt_r.rdata = din_sync;
          nxt_r.rsp = 1'b1;
          // Release selects and gate together, strobe high
          nxt_r.sel = 1'b0;
          nxt_r.oe_n = 1'b1;
          nxt_r.lane_n = LANES_NONE;
          nxt_r.st = ASL_REC;
          nxt_r.cnt = TURN_CYC;
        end
      end
      ASL_TURN:
      begin
        nxt_r.cnt = r_ff.cnt - 4'h1;
        if (r_ff.cnt == 4'h1)
        begin
          // Data driven only once bus is released
          nxt_r.drive = 1'b1;
          nxt_r.we_n = 1'b0;
          nxt_r.st = ASL_WR;
          nxt_r.cnt = WR_CYC;
        end
      end
      ASL_WR:
      begin
        nxt_r.cnt = r_ff.cnt - 4'h1;
        if (r_ff.cnt == 4'h1)
        begin
          // Strobe ends the write; data and selects held past it
          nxt_r.we_n = 1'b1;
          nxt_r.st = ASL_REC;
          nxt_r.cnt = REC_CYC;
        end
      end
      ASL_REC:
      begin
        nxt_r.cnt = r_ff.cnt - 4'h1;
        nxt_r.sel = 1'b0;
        nxt_r.lane_n = LANES_NONE;
        if (r_ff.cnt == REC_CYC)
        begin
          nxt_r.drive = 1'b0;
        end
        if (r_ff.cnt == 4'h1)
        begin
          nxt_r.st = ASL_IDLE;
        end
      end
      default:
      begin
        nxt_r.st = ASL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r_ff <= '{st: ASL_IDLE, cnt: 4'h0, addr: '0, wdata: '0, lane_n: LANES_NONE, sel: 1'b0,
               we_n: 1'b1, oe_n: 1'b1, drive: 1'b0, rsp: 1'b0, rdata: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign req_ready = (r_ff.st == ASL_IDLE);
  assign rsp_valid = r_ff.rsp;
  assign rsp_rdata = r_ff.rdata;
  assign sram_addr = r_ff.addr;
  // All controls always driven to a level
  assign chip_select_low_active = ~r_ff.sel;
  assign chip_select_high_active = r_ff.sel;
  assign write_strobe_n = r_ff.we_n;
  assign output_gate_n = r_ff.oe_n;
  assign upper_lane_enable_n = r_ff.lane_n[1];
  assign lower_lane_enable_n = r_ff.lane_n[0];
  assign data_lines_out = r_ff.wdata;
  assign data_lines_oe_n = {DATA_W{~r_ff.drive}};
endmodule : asl_host

/* include/asl_pkg.sv */
// Package of timing constants and states for the byte-lane SRAM host controller
package asl_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // Device timing figures in ns
  localparam int T_RC_NS = 45;
  localparam int T_AA_NS = 45;
  localparam int T_DOE_NS = 22;
  localparam int T_HZOE_NS = 18;
  localparam int T_PWE_NS = 35;
  localparam int T_SD_NS = 25;
  localparam int T_HZWE_NS = 18;
  localparam int T_HD_NS = 0;
  localparam int T_LZWE_NS = 10;
  // Cycle counts, least times rounded up, at least one
  localparam int RD_CYC_I = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_A = (T_SD_NS + T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_B = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_I = (WR_CYC_A > WR_CYC_B) ? WR_CYC_A : WR_CYC_B;
  localparam int TURN_CYC_I = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC_I = (T_LZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RD_CYC = 4'(RD_CYC_I < 1 ? 1 : RD_CYC_I);
  localparam logic [3:0] WR_CYC = 4'(WR_CYC_I < 1 ? 1 : WR_CYC_I);
  localparam logic [3:0] TURN_CYC = 4'(TURN_CYC_I < 1 ? 1 : TURN_CYC_I);
  localparam logic [3:0] REC_CYC = 4'(REC_CYC_I < 1 ? 1 : REC_CYC_I);
  localparam logic [1:0] LANES_NONE = 2'h3;
  typedef enum logic [2:0] {
    ASL_IDLE = 3'b000,
    ASL_RD = 3'b001,
    ASL_TURN = 3'b010,
    ASL_WR = 3'b011,
    ASL_REC = 3'b100
  } asl_state_t;
endpackage : asl_pkg

/* design/asl_sync2.sv */
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module asl_sync2
#(
  parameter int W = 16
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } asl_sync_t;

  asl_sync_t sync_ff;
  asl_sync_t nxt_sync;

  // Only the second stage reads the first
  always_comb
  begin
    nxt_sync.meta = d;
    nxt_sync.q = sync_ff.meta;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sync_ff <= '0;
    end
    else
    begin
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff.q;
endmodule : asl_sync2

/* verification/asl_host_properties.sv */
// Pin sequencing checks for the host controller
`timescale 1ns/1ps
module asl_host_props
  import asl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_lane_n,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_low_active,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic [DATA_W-1:0] data_lines_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic take = req_valid && req_ready && req_lane_n != 2'h3;
  sequence rd_hold;
    !output_gate_n [*4] ##1 output_gate_n;
  endsequence
  sequence wr_open;
    output_gate_n ##1 !write_strobe_n;
  endsequence
  a_read_strobe: assert property (!output_gate_n |-> write_strobe_n)
    else $error("strobe low while gate open");
  a_drive_gate: assert property (!data_lines_oe_n[0] |-> output_gate_n)
    else $error("host drives with gate open");
  a_strobe_sel: assert property (!write_strobe_n |-> !chip_select_low_active)
    else $error("strobe low while deselected");
  a_data_hold: assert property ($rose(write_strobe_n) |-> !data_lines_oe_n[0])
    else $error("data released at strobe end");
  a_strobe_width: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
    else $error("strobe width wrong");
  a_read_hold: assert property (take && !req_write |=> rd_hold)
    else $error("read controls not held");
  a_read_answer: assert property (take && !req_write |-> ##5 rsp_valid)
    else $error("read answer late");
  a_write_open: assert property (take && req_write |=> wr_open)
    else $error("write opened wrongly");
endmodule : asl_host_props
bind asl_host asl_host_props u_props (.*);

/* verification/asl_sram_model.sv */
// Behavioural byte-lane static RAM facing the host
`timescale 1ns/1ps
module asl_sram_model
  import asl_pkg::*;
(
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic [DATA_W-1:0] data_lines_oe_n,
  output logic [DATA_W-1:0] data_lines_in
);
  logic [DATA_W-1:0] mem [0:255];
  wire logic sel = !chip_select_low_active && chip_select_high_active;
  wire logic lane = !(upper_lane_enable_n && lower_lane_enable_n);
  wire logic wr = sel && lane && !write_strobe_n;
  wire logic rd = sel && write_strobe_n && !output_gate_n;
  wire logic [DATA_W-1:0] w = mem[sram_addr[7:0]];
  // Store at the edge that ends the write
  always @(negedge wr)
  begin
    if (!lower_lane_enable_n) mem[sram_addr[7:0]][7:0] = data_lines_out[7:0];
    if (!upper_lane_enable_n) mem[sram_addr[7:0]][15:8] = data_lines_out[15:8];
  end
  // Released lines show the inverse, except the true byte on a lane enabled during a read
  assign data_lines_in[7:0] = !data_lines_oe_n[0] ? data_lines_out[7:0] :
    (rd && !lower_lane_enable_n) ? w[7:0] : ~w[7:0];
  assign data_lines_in[15:8] = !data_lines_oe_n[8] ? data_lines_out[15:8] :
    (rd && !upper_lane_enable_n) ? w[15:8] : ~w[15:8];
endmodule : asl_sram_model

/* verification/async_sram_byte_lane_access_tb_top.sv */
// Testbench of the byte-lane SRAM host controller
`timescale 1ns/1ps
module async_sram_byte_lane_access_tb_top
  import asl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_lane_n = 2'h3;
  logic [ADDR_W-1:0] req_addr = 20'h00000;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, chip_select_low_active, chip_select_high_active;
  logic write_strobe_n, output_gate_n, upper_lane_enable_n, lower_lane_enable_n;
  logic [ADDR_W-1:0] sram_addr;
  logic [DATA_W-1:0] rsp_rdata, data_lines_in, data_lines_out, data_lines_oe_n, q;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  asl_host uut (.*);
  asl_sram_model u_mem (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lane_n <= ln;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    while (!(w ? req_ready : rsp_valid) && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 20) num_errors++;
    q = rsp_rdata;
    @(posedge clk_sys);
  endtask : xfer
  task automatic sc_word;
    xfer(1'b1, 20'h00005, 16'ha5c3, 2'h0);
    xfer(1'b0, 20'h00005, 16'h0000, 2'h0);
    check(q, 16'ha5c3);
  endtask : sc_word
  task automatic sc_lanes;
    xfer(1'b1, 20'h00009, 16'h1122, 2'h0);
    xfer(1'b1, 20'h00009, 16'hff33, 2'h2);
    xfer(1'b1, 20'h00009, 16'h44ff, 2'h1);
    xfer(1'b0, 20'h00009, 16'h0000, 2'h2);
    check({8'h00, q[7:0]}, 16'h0033);
    xfer(1'b0, 20'h00009, 16'h0000, 2'h1);
    check({8'h00, q[15:8]}, 16'h0044);
    xfer(1'b0, 20'h00009, 16'h0000, 2'h0);
    check(q, 16'h4433);
  endtask : sc_lanes
  task automatic sc_reset;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check({8'h00, req_ready, rsp_valid, chip_select_low_active, chip_select_high_active,
      write_strobe_n, output_gate_n, upper_lane_enable_n, lower_lane_enable_n},
      16'h00af);
    check(data_lines_oe_n, 16'hffff);
    @(posedge clk_sys);
    reset <= 1'b0;
    xfer(1'b0, 20'h00005, 16'h0000, 2'h0);
    check(q, 16'ha5c3);
  endtask : sc_reset
  task automatic sc_ignore;
    req_valid <= 1'b1;
    req_lane_n <= 2'h3;
    repeat (8)
    begin
      @(negedge clk_sys);
      check({14'h0000, req_ready, chip_select_low_active}, 16'h0003);
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : sc_ignore
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 500)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    sc_word();
    sc_ignore();
    sc_lanes();
    sc_reset();
    close_out();
  end
endmodule : async_sram_byte_lane_access_tb_top
